// file: src/fpwp_pkg.sv
package fpwp_pkg;

    // ============================================================
    // Instruction codes
    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
    localparam logic [7:0] OP_STATUS3_WRITE  = 8'hC0;
    localparam logic [7:0] OP_POWER_DOWN     = 8'hB9;
    localparam logic [7:0] OP_RELEASE        = 8'hAB;
    localparam logic [7:0] OP_RESET_ENABLE   = 8'h66;
    localparam logic [7:0] OP_RESET          = 8'h99;
    localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
    localparam logic [7:0] OP_QUAD_PROGRAM   = 8'h32;
    localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20;
    localparam logic [7:0] OP_HALF_ERASE     = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE    = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE     = 8'hC7;

    // ============================================================
    // Frame lengths in serial clock pulses
    localparam logic [11:0] BITS_CMD         = 12'h008;
    localparam logic [11:0] BITS_STATUS      = 12'h010;
    localparam logic [11:0] BITS_ADDR_CMD    = 12'h020;
    localparam logic [11:0] BITS_PROGRAM_MIN = 12'h028;
    localparam logic [11:0] BITS_MAX         = 12'hFFF;
    localparam int          OPCODE_LAST_BIT  = 7;
    localparam int          ADDR_LAST_BIT    = 31;

    // ============================================================
    // Status bit positions and reset values
    localparam int         SR_PROTECT_LSB  = 2;
    localparam int         SR_BOOT_LOCK    = 6;
    localparam int         SR_PERMANENT    = 7;
    localparam int         SR3_OTP_LOCK    = 1;
    localparam int         SR3_TOP_BOTTOM  = 3;
    localparam int         SR3_GRANULARITY = 4;
    localparam logic [3:0] PROTECT_RESET   = 4'h0;
    localparam logic [7:0] BLOCK_COUNT     = 8'h80;

    // ============================================================
    // Power-up write inhibit time
    localparam int TPUW_US      = 1000;
    localparam int CLK_MHZ      = 20;
    localparam int PUW_CYCLES   = TPUW_US * CLK_MHZ;

    // ============================================================
    // Types
    typedef enum logic [1:0] {
        FPWP_ACTIVE,
        FPWP_STANDBY,
        FPWP_POWER_DOWN
    } fpwp_power_t;

    typedef enum logic [2:0] {
        FPWP_OP_NONE,
        FPWP_OP_STATUS,
        FPWP_OP_PROGRAM,
        FPWP_OP_SECTOR,
        FPWP_OP_HALF_BLOCK,
        FPWP_OP_BLOCK,
        FPWP_OP_CHIP
    } fpwp_op_t;

    typedef struct packed {
        logic        valid;
        fpwp_op_t    op;
        logic [23:0] addr;
    } fpwp_exec_t;

    typedef struct packed {
        logic        ended;
        logic [11:0] bits;
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [7:0]  last_byte;
    } fpwp_frame_t;

    typedef struct packed {
        logic [3:0] protect_field;
        logic       permanent_protect_bit;
        logic       boot_lock_enable;
        logic       top_bottom_bit;
        logic       granularity;
        logic       otp_lock;
    } fpwp_prot_t;

endpackage

// file: src/fpwp_frame_rx.sv
`timescale 1ns/1ns
`default_nettype none
module fpwp_frame_rx (
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 cs_n_in,
    input  wire logic                 sclk_in,
    input  wire logic                 di_in,
    output var fpwp_pkg::fpwp_frame_t frame_out
);
    typedef struct packed {
        logic        sclk_q;
        logic        cs_n_q;
        logic [11:0] bits;
        logic [31:0] shift;
        logic [7:0]  opcode;
        logic [23:0] addr;
    } fpwp_rx_state_t;

    fpwp_rx_state_t s;
    fpwp_rx_state_t next_s;

    always_comb begin
        next_s        = s;
        next_s.sclk_q = sclk_in;
        next_s.cs_n_q = cs_n_in;
        if (cs_n_in) begin
            next_s.bits = '0;
        end else if (sclk_in && !s.sclk_q) begin
            next_s.shift = {s.shift[30:0], di_in};
            if (s.bits != fpwp_pkg::BITS_MAX) begin
                next_s.bits = s.bits + 12'h001;
            end
            if (s.bits == 12'(fpwp_pkg::OPCODE_LAST_BIT)) begin
                next_s.opcode = {s.shift[6:0], di_in};
            end
            if (s.bits == 12'(fpwp_pkg::ADDR_LAST_BIT)) begin
                next_s.addr = {s.shift[22:0], di_in};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s        <= '0;
            s.cs_n_q <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // The frame ends in the cycle the select line is seen high again.
    always_comb begin
        frame_out.ended     = cs_n_in && !s.cs_n_q;
        frame_out.bits      = s.bits;
        frame_out.opcode    = s.opcode;
        frame_out.addr      = s.addr;
        frame_out.last_byte = s.shift[7:0];
    end
endmodule
`default_nettype wire

// file: src/fpwp_protect_decode.sv
`timescale 1ns/1ns
`default_nettype none
module fpwp_protect_decode (
    input  wire fpwp_pkg::fpwp_prot_t prot_in,
    input  wire logic [23:0]       addr_in,
    output logic                   hit_out,
    output logic                   any_out
);
    function automatic logic [7:0] fpwp_span(input logic [3:0] field);
        logic [7:0] n;
        n = fpwp_pkg::BLOCK_COUNT;
        case (field)
            4'h0: n = 8'h00;
            4'h1: n = 8'h01;
            4'h2: n = 8'h02;
            4'h3: n = 8'h04;
            4'h4: n = 8'h08;
            4'h5: n = 8'h10;
            4'h6: n = 8'h20;
            4'h7: n = 8'h40;
            4'h8: n = 8'h60;
            4'h9: n = 8'h70;
            4'hA: n = 8'h78;
            4'hB: n = 8'h7C;
            4'hC: n = 8'h7E;
            4'hD: n = 8'h7F;
            default: n = fpwp_pkg::BLOCK_COUNT;
        endcase
        return n;
    endfunction

    logic [7:0] span;
    logic [7:0] blk;
    logic       range_hit;
    logic       boot_hit;

    always_comb begin
        span = fpwp_span(prot_in.protect_field);
        blk  = {1'b0, addr_in[22:16]};
        // Top counts down from the last block, bottom up from block zero.
        range_hit = prot_in.top_bottom_bit ? (blk < span)
                                           : (blk >= fpwp_pkg::BLOCK_COUNT - span);
        if (prot_in.granularity) begin
            boot_hit = prot_in.top_bottom_bit ? (addr_in[22:12] == 11'h000)
                                              : (addr_in[22:12] == 11'h7FF);
        end else begin
            boot_hit = prot_in.top_bottom_bit ? (blk == 8'h00) : (blk == 8'h7F);
        end
        hit_out = range_hit || (prot_in.boot_lock_enable && boot_hit);
        any_out = (span != 8'h00) || prot_in.boot_lock_enable;
    end
endmodule
`default_nettype wire

// file: src/fpwp_flash_guard.sv
`timescale 1ns/1ns
`default_nettype none
module fpwp_flash_guard #(
    parameter int PUW_CYCLES = fpwp_pkg::PUW_CYCLES
) (
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 cs_n_in,
    input  wire logic                 sclk_in,
    input  wire logic                 di_in,
    input  wire logic                 op_done_in,
    output var fpwp_pkg::fpwp_exec_t  exec_out,
    output var fpwp_pkg::fpwp_power_t power_out,
    output logic                      write_enable_latch_out,
    output var fpwp_pkg::fpwp_prot_t  prot_out,
    output logic                      software_protected_state_out,
    output logic                      busy_out,
    output logic                      puw_done_out,
    output logic                      refused_out
);
    // ============================================================
    // State
    typedef struct packed {
        fpwp_pkg::fpwp_power_t power;
        logic                  write_enable_latch;
        fpwp_pkg::fpwp_prot_t  prot;
        logic                  software_protected_state;
        logic                  tbg_locked;
        logic                  busy;
        logic                  reset_armed;
        logic [31:0]           puw;
        logic                  puw_done;
        fpwp_pkg::fpwp_exec_t  exec;
        logic                  refused;
    } fpwp_state_t;

    fpwp_state_t s;
    fpwp_state_t next_s;

    fpwp_pkg::fpwp_frame_t frame;
    logic                  hit;
    logic                  any_protected;

    // ============================================================
    // Serial frame capture
    fpwp_frame_rx u_rx (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .cs_n_in    (cs_n_in),
        .sclk_in    (sclk_in),
        .di_in      (di_in),
        .frame_out  (frame)
    );

    // ============================================================
    // Protected region lookup
    fpwp_protect_decode u_decode (
        .prot_in (s.prot),
        .addr_in (frame.addr),
        .hit_out (hit),
        .any_out (any_protected)
    );

    // ============================================================
    // Frame qualifiers
    logic byte_ok;
    logic may_modify;
    logic is_cmd_only;
    logic is_addr_only;
    logic is_status_len;
    logic is_program_len;

    always_comb begin
        byte_ok        = (frame.bits[2:0] == 3'h0) && (frame.bits != 12'h000);
        is_cmd_only    = frame.bits == fpwp_pkg::BITS_CMD;
        is_addr_only   = frame.bits == fpwp_pkg::BITS_ADDR_CMD;
        is_status_len  = frame.bits == fpwp_pkg::BITS_STATUS;
        is_program_len = frame.bits >= fpwp_pkg::BITS_PROGRAM_MIN;
        // Refusing here, not at the opcode, means a short frame never
        // touches the latch, so a clipped page program leaves it set.
        may_modify     = byte_ok && s.write_enable_latch && s.puw_done;
    end

    // ============================================================
    // Next state
    always_comb begin
        next_s            = s;
        next_s.exec.valid = 1'b0;
        next_s.refused    = 1'b0;

        if (!s.puw_done) begin
            if (s.puw == 32'(PUW_CYCLES - 1)) begin
                next_s.puw_done = 1'b1;
            end else begin
                next_s.puw = s.puw + 32'h0000_0001;
            end
        end

        if (s.busy && op_done_in) begin
            next_s.busy = 1'b0;
            next_s.write_enable_latch  = 1'b0;
        end

        if (frame.ended) begin
            if (s.power == fpwp_pkg::FPWP_POWER_DOWN) begin
                if (frame.opcode == fpwp_pkg::OP_RELEASE && frame.bits >= fpwp_pkg::BITS_CMD) begin
                    next_s.power = fpwp_pkg::FPWP_STANDBY;
                end
                // Anything else is dropped here, which keeps the array safe.
            end else if (!s.busy) begin
                next_s.reset_armed = 1'b0;
                case (frame.opcode)
                    fpwp_pkg::OP_WRITE_ENABLE: begin
                        if (is_cmd_only) begin
                            next_s.write_enable_latch = 1'b1;
                        end
                    end

                    fpwp_pkg::OP_WRITE_DISABLE: begin
                        if (is_cmd_only) begin
                            next_s.write_enable_latch = 1'b0;
                        end
                    end

                    fpwp_pkg::OP_POWER_DOWN: begin
                        if (is_cmd_only) begin
                            next_s.power = fpwp_pkg::FPWP_POWER_DOWN;
                        end
                    end

                    fpwp_pkg::OP_RESET_ENABLE: begin
                        next_s.reset_armed = is_cmd_only;
                    end

                    fpwp_pkg::OP_RESET: begin
                        if (is_cmd_only && s.reset_armed) begin
                            next_s.write_enable_latch = 1'b0;
                        end
                    end

                    fpwp_pkg::OP_STATUS_WRITE: begin
                        if (may_modify && is_status_len) begin
                            if (!s.prot.permanent_protect_bit) begin
                                next_s.prot.protect_field =
                                    frame.last_byte[fpwp_pkg::SR_PROTECT_LSB +: 4];
                                next_s.prot.permanent_protect_bit =
                                    frame.last_byte[fpwp_pkg::SR_PERMANENT];
                            end
                            next_s.prot.boot_lock_enable =
                                frame.last_byte[fpwp_pkg::SR_BOOT_LOCK];
                            next_s.busy      = 1'b1;
                            next_s.exec.valid = 1'b1;
                            next_s.exec.op   = fpwp_pkg::FPWP_OP_STATUS;
                            next_s.exec.addr = '0;
                        end else begin
                            next_s.refused = 1'b1;
                        end
                    end

                    fpwp_pkg::OP_STATUS3_WRITE: begin
                        if (may_modify && is_status_len) begin
                            if (!s.tbg_locked) begin
                                next_s.prot.top_bottom_bit =
                                    frame.last_byte[fpwp_pkg::SR3_TOP_BOTTOM];
                                next_s.prot.granularity =
                                    frame.last_byte[fpwp_pkg::SR3_GRANULARITY];
                                next_s.tbg_locked = 1'b1;
                            end
                            if (!s.prot.permanent_protect_bit) begin
                                next_s.prot.otp_lock =
                                    frame.last_byte[fpwp_pkg::SR3_OTP_LOCK];
                            end
                            next_s.busy      = 1'b1;
                            next_s.exec.valid = 1'b1;
                            next_s.exec.op   = fpwp_pkg::FPWP_OP_STATUS;
                            next_s.exec.addr = '0;
                        end else begin
                            next_s.refused = 1'b1;
                        end
                    end

                    fpwp_pkg::OP_PAGE_PROGRAM,
                    fpwp_pkg::OP_QUAD_PROGRAM: begin
                        if (may_modify && is_program_len && !hit) begin
                            next_s.busy      = 1'b1;
                            next_s.exec.valid = 1'b1;
                            next_s.exec.op   = fpwp_pkg::FPWP_OP_PROGRAM;
                            next_s.exec.addr = frame.addr;
                        end else begin
                            next_s.refused = 1'b1;
                        end
                    end

                    fpwp_pkg::OP_SECTOR_ERASE,
                    fpwp_pkg::OP_HALF_ERASE,
                    fpwp_pkg::OP_BLOCK_ERASE: begin
                        if (may_modify && is_addr_only && !hit) begin
                            next_s.busy      = 1'b1;
                            next_s.exec.valid = 1'b1;
                            next_s.exec.addr = frame.addr;
                            if (frame.opcode == fpwp_pkg::OP_SECTOR_ERASE) begin
                                next_s.exec.op = fpwp_pkg::FPWP_OP_SECTOR;
                            end else if (frame.opcode == fpwp_pkg::OP_HALF_ERASE) begin
                                next_s.exec.op = fpwp_pkg::FPWP_OP_HALF_BLOCK;
                            end else begin
                                next_s.exec.op = fpwp_pkg::FPWP_OP_BLOCK;
                            end
                        end else begin
                            next_s.refused = 1'b1;
                        end
                    end

                    fpwp_pkg::OP_CHIP_ERASE: begin
                        // Any protection at all blocks a whole-array erase.
                        if (may_modify && is_cmd_only && !any_protected) begin
                            next_s.busy      = 1'b1;
                            next_s.exec.valid = 1'b1;
                            next_s.exec.op   = fpwp_pkg::FPWP_OP_CHIP;
                            next_s.exec.addr = '0;
                        end else begin
                            next_s.refused = 1'b1;
                        end
                    end

                    default: begin
                    end
                endcase
            end
        end else begin
            case (s.power)
                fpwp_pkg::FPWP_ACTIVE: begin
                    if (cs_n_in && !s.busy) begin
                        next_s.power = fpwp_pkg::FPWP_STANDBY;
                    end
                end

                fpwp_pkg::FPWP_STANDBY: begin
                    if (!cs_n_in) begin
                        next_s.power = fpwp_pkg::FPWP_ACTIVE;
                    end
                end

                default: begin
                end
            endcase
        end

        next_s.software_protected_state = next_s.prot.protect_field != fpwp_pkg::PROTECT_RESET;
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s       <= '0;
            s.power <= fpwp_pkg::FPWP_STANDBY;
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // Outputs
    always_comb begin
        exec_out                     = s.exec;
        power_out                    = s.power;
        write_enable_latch_out       = s.write_enable_latch;
        prot_out                     = s.prot;
        software_protected_state_out = s.software_protected_state;
        busy_out                     = s.busy;
        puw_done_out                 = s.puw_done;
        refused_out                  = s.refused;
    end
endmodule
`default_nettype wire

// file: dv/fpwp_flash_guard_chk.sv
`timescale 1ns/1ns
`default_nettype none
module fpwp_flash_guard_chk #(
    parameter int PUW_CYCLES = fpwp_pkg::PUW_CYCLES
) (
    input wire logic                  clk_in,
    input wire logic                  sys_rst_in,
    input wire logic                  cs_n_in,
    input wire logic                  sclk_in,
    input wire logic                  di_in,
    input wire logic                  op_done_in,
    input wire fpwp_pkg::fpwp_exec_t  exec_out,
    input wire fpwp_pkg::fpwp_power_t power_out,
    input wire logic                  write_enable_latch_out,
    input wire fpwp_pkg::fpwp_prot_t  prot_out,
    input wire logic                  software_protected_state_out,
    input wire logic                  busy_out,
    input wire logic                  puw_done_out,
    input wire logic                  refused_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence busy_ends;
        busy_out ##1 !busy_out;
    endsequence
    sequence frame_closed;
        !$past(cs_n_in, 2) && $past(cs_n_in, 1);
    endsequence
    frame_end_a: assert property (exec_out.valid || refused_out |-> frame_closed)
        else $error("answer without a frame end one cycle before");
    select_active_a: assert property (!cs_n_in && power_out != fpwp_pkg::FPWP_POWER_DOWN
        |=> power_out == fpwp_pkg::FPWP_ACTIVE) else $error("selected but not active");
    busy_active_a: assert property (busy_out |-> power_out == fpwp_pkg::FPWP_ACTIVE)
        else $error("stand-by during an internal cycle");
    wel_gate_a: assert property (exec_out.valid |-> $past(write_enable_latch_out))
        else $error("execution with latch clear");
    puw_gate_a: assert property (exec_out.valid |-> $past(puw_done_out))
        else $error("execution before power-up timer expired");
    pd_silent_a: assert property (power_out == fpwp_pkg::FPWP_POWER_DOWN |=> !exec_out.valid)
        else $error("execution in deep power-down");
    refuse_keep_a: assert property (refused_out |-> !exec_out.valid && $stable(write_enable_latch_out))
        else $error("refusal changed the latch");
    busy_clear_a: assert property (busy_ends |-> !write_enable_latch_out)
        else $error("latch still set after internal cycle");
    spm_map_a: assert property ($stable(prot_out.protect_field)
        |-> software_protected_state_out == (prot_out.protect_field != 4'h0)) else $error("protect state wrong");
    perm_freeze_a: assert property (prot_out.permanent_protect_bit |=> prot_out.permanent_protect_bit
        && $stable(prot_out.protect_field) && $stable(prot_out.otp_lock)) else $error("frozen bits changed");
endmodule
bind fpwp_flash_guard fpwp_flash_guard_chk #(.PUW_CYCLES(PUW_CYCLES)) chk_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in), .di_in(di_in),
    .op_done_in(op_done_in), .exec_out(exec_out), .power_out(power_out),
    .write_enable_latch_out(write_enable_latch_out), .prot_out(prot_out),
    .software_protected_state_out(software_protected_state_out), .busy_out(busy_out),
    .puw_done_out(puw_done_out), .refused_out(refused_out));
`default_nettype wire

// file: dv/fpwp_spi_host.sv
`timescale 1ns/1ns
`default_nettype none
module fpwp_spi_host (
    input  wire logic clk_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      di_out
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        di_out   = 1'b0;
    end
    // Clock rests low between frames; data is inverted once released so no stale bit looks valid.
    task automatic send(input logic [63:0] bits, input int n);
        @(negedge clk_in);
        cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            di_out = bits[63 - i];
            repeat (2) @(negedge clk_in);
            sclk_out = 1'b1;
            repeat (2) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        @(negedge clk_in);
        cs_n_out = 1'b1;
        di_out   = ~di_out;
        repeat (3) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// file: dv/tb_fpwp_flash_guard.sv
`timescale 1ns/1ns
`default_nettype none
module tb_fpwp_flash_guard;
    logic                 clk_in, sys_rst_in, cs_n, sclk, di, op_done_in;
    logic                 write_enable_latch, software_protected_state, busy, puw_done, refused;
    fpwp_pkg::fpwp_exec_t exec_out, last_exec;
    fpwp_pkg::fpwp_power_t power_out;
    fpwp_pkg::fpwp_prot_t prot_out;
    int                   bad_count, check_count, exec_cnt, ref_cnt, eng_cnt;

    fpwp_spi_host host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .di_out(di));
    fpwp_flash_guard #(.PUW_CYCLES(200)) uut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n), .sclk_in(sclk), .di_in(di),
        .op_done_in(op_done_in), .exec_out(exec_out), .power_out(power_out),
        .write_enable_latch_out(write_enable_latch), .prot_out(prot_out), .software_protected_state_out(software_protected_state),
        .busy_out(busy), .puw_done_out(puw_done), .refused_out(refused));

    always #25 clk_in = ~clk_in;

    // Array engine finishes every internal cycle a few clocks after it starts.
    always @(negedge clk_in) begin
        op_done_in <= (eng_cnt == 1);
        if (eng_cnt != 0) eng_cnt <= eng_cnt - 1;
        else if (exec_out.valid === 1'b1) eng_cnt <= 4;
        if (exec_out.valid === 1'b1) last_exec <= exec_out;
        if (exec_out.valid === 1'b1) exec_cnt <= exec_cnt + 1;
        if (refused === 1'b1) ref_cnt <= ref_cnt + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Sends one frame, optionally after a write enable, then counts executions and refusals.
    task automatic run(input logic [63:0] v, input int n, input bit we, input int e, input int r);
        int e0, r0;
        e0 = exec_cnt;
        r0 = ref_cnt;
        if (we) host.send({fpwp_pkg::OP_WRITE_ENABLE, 56'h0}, 8);
        host.send(v, n);
        for (int k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk_in);
        repeat (2) @(negedge clk_in);
        if (e >= 0) chk(exec_cnt - e0, e);
        if (r >= 0) chk(ref_cnt - r0, r);
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        stop_test();
    end

    initial begin
        clk_in = 1'b0;
        sys_rst_in = 1'b1;
        repeat (3) @(negedge clk_in);
        sys_rst_in = 1'b0;
        chk(32'(power_out), 32'(fpwp_pkg::FPWP_STANDBY));
        chk(32'(prot_out), 32'h0);
        chk(32'(write_enable_latch), 32'h0);
        run({fpwp_pkg::OP_SECTOR_ERASE, 56'h0}, 32, 1, 0, 1);
        for (int k = 0; k < 400 && puw_done !== 1'b1; k++) @(negedge clk_in);
        chk(32'(puw_done), 32'h1);
        run({fpwp_pkg::OP_PAGE_PROGRAM, 32'h0001005A, 24'h0}, 44, 1, 0, 1);
        chk(32'(write_enable_latch), 32'h1);
        run({fpwp_pkg::OP_PAGE_PROGRAM, 32'h0001005A, 24'h0}, 40, 0, 1, 0);
        chk(32'(last_exec), 32'({1'b1, fpwp_pkg::FPWP_OP_PROGRAM, 24'h000100}));
        chk(32'(write_enable_latch), 32'h0);
        chk(32'(power_out), 32'(fpwp_pkg::FPWP_STANDBY));
        run({fpwp_pkg::OP_PAGE_PROGRAM, 32'h0001005A, 24'h0}, 40, 0, 0, 1);
        run({fpwp_pkg::OP_STATUS_WRITE, 8'h04, 48'h0}, 16, 1, 1, 0);
        chk(32'(software_protected_state), 32'h1);
        run({fpwp_pkg::OP_SECTOR_ERASE, 24'h7F0000, 32'h0}, 32, 1, 0, 1);
        run({fpwp_pkg::OP_SECTOR_ERASE, 24'h7E0000, 32'h0}, 32, 1, 1, 0);
        chk(32'(last_exec), 32'({1'b1, fpwp_pkg::FPWP_OP_SECTOR, 24'h7E0000}));
        run({fpwp_pkg::OP_STATUS3_WRITE, 8'h08, 48'h0}, 16, 1, 1, 0);
        run({fpwp_pkg::OP_SECTOR_ERASE, 56'h0}, 32, 1, 0, 1);
        run({fpwp_pkg::OP_STATUS3_WRITE, 8'h00, 48'h0}, 16, 1, -1, -1);
        chk(32'(prot_out.top_bottom_bit), 32'h1);
        run({fpwp_pkg::OP_STATUS_WRITE, 8'h84, 48'h0}, 16, 1, 1, 0);
        run({fpwp_pkg::OP_STATUS_WRITE, 8'h00, 48'h0}, 16, 1, -1, -1);
        chk(32'(prot_out.protect_field), 32'h1);
        run({fpwp_pkg::OP_WRITE_DISABLE, 56'h0}, 8, 1, 0, 0);
        chk(32'(write_enable_latch), 32'h0);
        run({fpwp_pkg::OP_RESET_ENABLE, 56'h0}, 8, 1, 0, 0);
        run({fpwp_pkg::OP_RESET, 56'h0}, 8, 0, 0, 0);
        chk(32'(write_enable_latch), 32'h0);
        run({fpwp_pkg::OP_POWER_DOWN, 56'h0}, 8, 0, 0, 0);
        chk(32'(power_out), 32'(fpwp_pkg::FPWP_POWER_DOWN));
        run({fpwp_pkg::OP_SECTOR_ERASE, 24'h7E0000, 32'h0}, 32, 1, 0, 0);
        chk(32'(write_enable_latch), 32'h0);
        run({fpwp_pkg::OP_RELEASE, 56'h0}, 8, 0, 0, 0);
        chk(32'(power_out), 32'(fpwp_pkg::FPWP_STANDBY));
        run({fpwp_pkg::OP_CHIP_ERASE, 56'h0}, 8, 1, 0, 1);
        run({fpwp_pkg::OP_BLOCK_ERASE, 24'h400000, 32'h0}, 32, 1, 1, 0);
        chk(32'(last_exec), 32'({1'b1, fpwp_pkg::FPWP_OP_BLOCK, 24'h400000}));
        run({fpwp_pkg::OP_HALF_ERASE, 24'h008000, 32'h0}, 32, 1, 0, 1);
        run({fpwp_pkg::OP_QUAD_PROGRAM, 32'h0100005A, 24'h0}, 40, 1, 1, 0);
        chk(32'(last_exec), 32'({1'b1, fpwp_pkg::FPWP_OP_PROGRAM, 24'h010000}));
        run({fpwp_pkg::OP_STATUS_WRITE, 8'h40, 48'h0}, 16, 1, 1, 0);
        chk(32'(prot_out.boot_lock_enable), 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
